// ### pic_pkg.sv
// Purpose: Shared constants of the prioritized interrupt controller
// Assumes: APB byte addresses, 32-bit data, registers in the low bits
package pic_pkg;
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CORE = 8'h04;
   localparam logic [7:0] OFS_GCTL1 = 8'h08;
   localparam logic [7:0] OFS_GCTL2 = 8'h0c;
   localparam logic [7:0] OFS_GCTL3 = 8'h10;
   localparam logic [7:0] OFS_GCTL4 = 8'h14;
   localparam logic [7:0] OFS_PEND = 8'h18;
   localparam logic [7:0] OFS_FLAG = 8'h20;
   localparam logic [7:0] OFS_ENAB = 8'h24;
   localparam logic [7:0] OFS_PRIO = 8'h28;
   localparam int LVL_LSB = 5;
   localparam int MSB_BIT = 3;
   localparam int NESTING_DISABLE_BIT = 15;
   localparam int TRAP_LSB = 1;
   localparam int N_TRAP = 4;
   localparam int GIE_BIT = 15;
   localparam int DMA_TRAP_BIT = 5;
   localparam int LOOP_TRAP_BIT = 4;
   localparam int SOFT_TRAP_BIT = 0;
   localparam int PEND_LVL_LSB = 8;
   localparam int PRIO_PER_REG = 4;
   localparam logic [7:0] VEC_BASE = 8'h08;
   localparam logic [2:0] LVL_RESET = 3'h0;
   localparam logic [2:0] PRIO_RESET = 3'h4;
endpackage : pic_pkg

// ### pic_arb_if.sv
// Purpose: Carries requests into the resolver and its choice back
// Assumes: One clock, resolver is purely combinational
// Notes: Priorities packed three bits per source
`timescale 1ns/1ps
interface pic_arb_if #(parameter int N_SRC = 16);
   logic [N_SRC-1:0] req;
   logic [3*N_SRC-1:0] prio;
   logic [3:0] level;
   logic valid;
   logic [7:0] idx;
   logic [2:0] win_prio;
   modport ctl (output req, output prio, output level,
      input valid, input idx, input win_prio);
   modport arb (input req, input prio, input level,
      output valid, output idx, output win_prio);
endinterface : pic_arb_if

// ### pic_sync.sv
// Purpose: Two-stage synchroniser for external request pins
// Assumes: Pins are asynchronous to pclk
// Notes: First stage feeds the second stage only
`timescale 1ns/1ps
module pic_sync #(
   parameter int W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         pin_out <= '0;
      end
      else
      begin
         meta_q <= pin_in;
         pin_out <= meta_q;
      end
   end
endmodule : pic_sync

// ### pic_arb.sv
// Purpose: Picks the winning request among pending sources
// Assumes: Requests already gated by flag and enable
// Notes: Strictly greater test keeps the lowest index on ties
`timescale 1ns/1ps
module pic_arb #(
   parameter int N_SRC = 16
) (
   pic_arb_if.arb a
);
   logic [2:0] best_p;
   logic [7:0] best_i;
   logic found;

   always_comb
   begin
      best_p = 3'h0;
      best_i = 8'h00;
      found = 1'b0;
      for (int i = 0; i < N_SRC; i++)
      begin
         // Msb set or level seven leaves nothing above the level
         if (a.req[i] && !a.level[3] &&
             a.prio[3*i +: 3] > a.level[2:0] &&
             (!found || a.prio[3*i +: 3] > best_p))
         begin
            best_p = a.prio[3*i +: 3];
            best_i = 8'(i);
            found = 1'b1;
         end
      end
      a.valid = found;
      a.idx = best_i;
      a.win_prio = best_p;
   end
endmodule : pic_arb

// ### pic_ctrl.sv
// Purpose: Prioritized vectored interrupt controller with APB registers
// Assumes: Peripheral and trap events are pclk pulses; ext pins async
// Notes: Zero-wait APB reads return data registered in the setup cycle
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module pic_ctrl #(
   parameter int N_SRC = 16,
   parameter int N_EXT = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_EXT-1:0] ext_irq_pin,
   input wire logic [N_SRC-N_EXT-1:0] periph_evt,
   input wire logic [pic_pkg::N_TRAP-1:0] trap_evt,
   input wire logic dma_trap_evt,
   input wire logic loop_ovf_evt,
   input wire logic trap_enter,
   input wire logic trap_exit,
   input wire logic irq_ack,
   output logic irq,
   output logic trap_irq,
   output logic [7:0] irq_vector,
   output logic [3:0] irq_level
);
   localparam int NPR = N_SRC / pic_pkg::PRIO_PER_REG;

   // Register state
   logic [2:0] level_q;
   logic msb_q;
   logic nesting_disable_q;
   logic [pic_pkg::N_TRAP-1:0] trap_flag_q;
   logic gie_q;
   logic [N_EXT-1:0] ext_pol_q;
   logic dma_flag_q;
   logic loop_flag_q;
   logic soft_trap_q;
   logic [7:0] pend_vec_q;
   logic [3:0] pend_lvl_q;
   logic [N_SRC-1:0] flag_q;
   logic [N_SRC-1:0] enab_q;
   logic [2:0] prio_q [N_SRC];

   // External pin edge detection
   logic [N_EXT-1:0] ext_s;
   logic [N_EXT-1:0] ext_prev_q;
   logic [N_EXT-1:0] ext_edge;
   logic [N_SRC-1:0] src_evt;

   // Bus decode
   logic setup;
   logic wr;
   logic [31:0] rd_d;
   logic hit_d;

   pic_arb_if #(.N_SRC(N_SRC)) arb_bus ();

   pic_sync #(.W(N_EXT)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(ext_irq_pin),
      .pin_out(ext_s)
   );

   pic_arb #(.N_SRC(N_SRC)) u_arb (
      .a(arb_bus)
   );

   function automatic logic is_reg(input logic [7:0] a,
      input logic [7:0] ofs);
      is_reg = (a == ofs);
   endfunction : is_reg

   function automatic logic is_prio(input logic [7:0] a);
      is_prio = a >= pic_pkg::OFS_PRIO &&
         a < pic_pkg::OFS_PRIO + 8'(4 * NPR) && a[1:0] == 2'b00;
   endfunction : is_prio

   // Byte address of the priority word that holds source i
   function automatic logic [7:0] prio_ofs(input int i);
      prio_ofs = pic_pkg::OFS_PRIO + 8'(4 * (i / pic_pkg::PRIO_PER_REG));
   endfunction : prio_ofs

   // Position of source i inside its priority word
   function automatic int prio_lsb(input int i);
      prio_lsb = 4 * (i % pic_pkg::PRIO_PER_REG);
   endfunction : prio_lsb

   assign setup = psel && !penable;
   // Write commits only at the access edge where pready is seen high
   assign wr = psel && penable && pwrite && pready;

   // Pins are synchronised before the edge logic reads them
   // A pin held high through reset shows one rising edge on release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_prev_q <= '0;
      else
         ext_prev_q <= ext_s;
   end

   // Polarity bit high selects the falling edge
   assign ext_edge = (ext_s & ~ext_prev_q & ~ext_pol_q) |
      (~ext_s & ext_prev_q & ext_pol_q);
   // Pins take the lowest positions, ahead of peripherals
   assign src_evt = {periph_evt, ext_edge};

   // Per-source flags: set wins over a simultaneous clear
   generate
      for (genvar i = 0; i < N_SRC; i++)
      begin : g_src
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               flag_q[i] <= 1'b0;
            else if (src_evt[i])
               flag_q[i] <= 1'b1;
            else if (wr && is_reg(paddr, pic_pkg::OFS_FLAG) && pwdata[i])
               flag_q[i] <= 1'b0;
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               prio_q[i] <= pic_pkg::PRIO_RESET;
            else if (wr && is_reg(paddr, prio_ofs(i)))
               prio_q[i] <= pwdata[prio_lsb(i) +: 3];
         end

         assign arb_bus.prio[3*i +: 3] = prio_q[i];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         enab_q <= '0;
      else if (wr && is_reg(paddr, pic_pkg::OFS_ENAB))
         enab_q <= pwdata[N_SRC-1:0];
   end

   // Flag and enable together form the masked status
   assign arb_bus.req = flag_q & enab_q;
   assign arb_bus.level = {msb_q, level_q};

   // CPU level: acknowledge raises it to the taken priority
   // Acknowledge wins over a bus write to the level in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level_q <= pic_pkg::LVL_RESET;
      else if (irq_ack && irq)
         level_q <= pend_lvl_q[2:0];
      else if (wr && is_reg(paddr, pic_pkg::OFS_STATUS) && !nesting_disable_q)
         level_q <= pwdata[pic_pkg::LVL_LSB +: 3];
   end

   // Msb moves only with trap entry and exit, never by a bus write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         msb_q <= 1'b0;
      else if (trap_enter)
         msb_q <= 1'b1;
      else if (trap_exit)
         msb_q <= 1'b0;
   end

   // First global control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         nesting_disable_q <= 1'b0;
      else if (wr && is_reg(paddr, pic_pkg::OFS_GCTL1))
         nesting_disable_q <= pwdata[pic_pkg::NESTING_DISABLE_BIT];
   end

   // Trap flags: an event wins over a write-one clear in one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trap_flag_q <= '0;
      else
         trap_flag_q <= trap_evt | (trap_flag_q &
            ~({pic_pkg::N_TRAP{wr && is_reg(paddr, pic_pkg::OFS_GCTL1)}} &
            pwdata[pic_pkg::TRAP_LSB +: pic_pkg::N_TRAP]));
   end

   // Second global control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gie_q <= 1'b0;
         ext_pol_q <= '0;
      end
      else if (wr && is_reg(paddr, pic_pkg::OFS_GCTL2))
      begin
         gie_q <= pwdata[pic_pkg::GIE_BIT];
         ext_pol_q <= pwdata[N_EXT-1:0];
      end
   end

   // Third global control: sticky, write one to clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dma_flag_q <= 1'b0;
         loop_flag_q <= 1'b0;
      end
      else
      begin
         dma_flag_q <= dma_trap_evt || (dma_flag_q &&
            !(wr && is_reg(paddr, pic_pkg::OFS_GCTL3) &&
            pwdata[pic_pkg::DMA_TRAP_BIT]));
         loop_flag_q <= loop_ovf_evt || (loop_flag_q &&
            !(wr && is_reg(paddr, pic_pkg::OFS_GCTL3) &&
            pwdata[pic_pkg::LOOP_TRAP_BIT]));
      end
   end

   // Fourth global control: software raises and drops the hard trap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         soft_trap_q <= 1'b0;
      else if (wr && is_reg(paddr, pic_pkg::OFS_GCTL4))
         soft_trap_q <= pwdata[pic_pkg::SOFT_TRAP_BIT];
   end

   // Pending vector tracks the current winner; holds when none pends
   // The core takes its new level from here, so both fields move together
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_vec_q <= 8'h00;
         pend_lvl_q <= 4'h0;
      end
      else if (arb_bus.valid)
      begin
         pend_vec_q <= pic_pkg::VEC_BASE + arb_bus.idx;
         pend_lvl_q <= {1'b0, arb_bus.win_prio};
      end
   end

   // Interrupt outputs, all registered
   // Registering irq keeps it in step with the pending vector
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
         trap_irq <= 1'b0;
      end
      else
      begin
         irq <= gie_q && arb_bus.valid;
         // Traps bypass the CPU level and the global enable
         trap_irq <= |trap_flag_q || dma_flag_q || loop_flag_q ||
            soft_trap_q;
      end
   end

   assign irq_vector = pend_vec_q;
   assign irq_level = pend_lvl_q;

   // Read mux, evaluated in the setup cycle
   always_comb
   begin
      rd_d = 32'h0000_0000;
      hit_d = 1'b1;
      if (is_reg(paddr, pic_pkg::OFS_STATUS))
         rd_d[pic_pkg::LVL_LSB +: 3] = level_q;
      else if (is_reg(paddr, pic_pkg::OFS_CORE))
         rd_d[pic_pkg::MSB_BIT] = msb_q;
      else if (is_reg(paddr, pic_pkg::OFS_GCTL1))
      begin
         rd_d[pic_pkg::NESTING_DISABLE_BIT] = nesting_disable_q;
         rd_d[pic_pkg::TRAP_LSB +: pic_pkg::N_TRAP] = trap_flag_q;
      end
      else if (is_reg(paddr, pic_pkg::OFS_GCTL2))
      begin
         rd_d[pic_pkg::GIE_BIT] = gie_q;
         rd_d[N_EXT-1:0] = ext_pol_q;
      end
      else if (is_reg(paddr, pic_pkg::OFS_GCTL3))
      begin
         rd_d[pic_pkg::DMA_TRAP_BIT] = dma_flag_q;
         rd_d[pic_pkg::LOOP_TRAP_BIT] = loop_flag_q;
      end
      else if (is_reg(paddr, pic_pkg::OFS_GCTL4))
         rd_d[pic_pkg::SOFT_TRAP_BIT] = soft_trap_q;
      else if (is_reg(paddr, pic_pkg::OFS_PEND))
      begin
         rd_d[7:0] = pend_vec_q;
         rd_d[pic_pkg::PEND_LVL_LSB +: 4] = pend_lvl_q;
      end
      else if (is_reg(paddr, pic_pkg::OFS_FLAG))
         rd_d[N_SRC-1:0] = flag_q;
      else if (is_reg(paddr, pic_pkg::OFS_ENAB))
         rd_d[N_SRC-1:0] = enab_q;
      else if (is_prio(paddr))
      begin
         for (int i = 0; i < N_SRC; i++)
         begin
            if (is_reg(paddr, prio_ofs(i)))
               rd_d[prio_lsb(i) +: 3] = prio_q[i];
         end
      end
      else
         hit_d = 1'b0;
   end

   // APB answer: ready rises in the first access cycle, no wait states
   // Read data are taken at setup, so any earlier write is already seen
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (setup)
      begin
         pready <= 1'b1;
         pslverr <= !hit_d;
         prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : pic_ctrl

// ### pic_ctrl_asserts.sv
// Purpose: Port-level checks of the interrupt controller
// Assumes: Zero-wait APB slave, registered interrupt outputs
// Notes: Bound to every pic_ctrl instance
`timescale 1ns/1ps
module pic_ctrl_asserts #(
   parameter int N_SRC = 16,
   parameter int N_EXT = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [pic_pkg::N_TRAP-1:0] trap_evt,
   input wire logic trap_enter,
   input wire logic irq_ack,
   input wire logic irq,
   input wire logic trap_irq,
   input wire logic [7:0] irq_vector,
   input wire logic [3:0] irq_level
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence rd_s(logic [7:0] ofs);
      psel && penable && pready && !pwrite && paddr == ofs;
   endsequence
   acc_ready_a: assert property (setup_s |=> pready)
      else $error("no ready in first access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   msb_block_a: assert property (trap_enter |-> ##2 !irq)
      else $error("interrupt while level msb set");
   vec_range_a: assert property (irq |-> irq_vector >= 8'h08 &&
      irq_vector < pic_pkg::VEC_BASE + N_SRC)
      else $error("vector outside source range");
   pend_lvl_a: assert property (irq |-> irq_level inside {[4'h1:4'h7]})
      else $error("pending level not a user priority");
   trap_flag_a: assert property (|trap_evt |-> ##2 trap_irq)
      else $error("trap event not flagged");
   stat_read_a: assert property (rd_s(pic_pkg::OFS_STATUS) |->
      (prdata & 32'hffffff1f) == 32'h0)
      else $error("status word stray bits");
   core_read_a: assert property (rd_s(pic_pkg::OFS_CORE) |->
      (prdata & 32'hfffffff7) == 32'h0)
      else $error("core control stray bits");
   ack_drop_a: assert property (irq && irq_ack |-> ##2
      (!irq || irq_level > $past(irq_level, 2)))
      else $error("taken request still offered");
endmodule : pic_ctrl_asserts

bind pic_ctrl pic_ctrl_asserts #(.N_SRC(N_SRC), .N_EXT(N_EXT)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .trap_evt, .trap_enter, .irq_ack, .irq, .trap_irq, .irq_vector,
   .irq_level);

// ### pic_cpu_model.sv
// Purpose: Processor core stand-in that takes interrupts
// Assumes: irq_ack is a one-cycle pulse after ack_dly waiting cycles
// Notes: A delay of zero would take one request twice
`timescale 1ns/1ps
module pic_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq,
   input wire logic ack_en,
   input wire logic [3:0] ack_dly,
   output logic irq_ack
);
   logic [3:0] wait_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wait_q <= 4'h0;
      else if (!irq || !ack_en || irq_ack || wait_q == ack_dly)
         wait_q <= 4'h0;
      else
         wait_q <= wait_q + 4'h1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_ack <= 1'b0;
      else
         irq_ack <= irq && ack_en && !irq_ack && wait_q == ack_dly;
   end
endmodule : pic_cpu_model

// ### prioritized_interrupt_controller_tb_top.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero-wait APB slave, core stand-in acknowledges on request
// Notes: One task per scenario, every wait bounded
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] ext_pin = 3'h0;
   logic [12:0] pevt = 13'h0;
   logic [3:0] tevt = 4'h0;
   logic t_enter = 1'b0;
   logic t_exit = 1'b0;
   logic dma_evt = 1'b0;
   logic loop_evt = 1'b0;
   logic ack_en = 1'b0;
   logic [3:0] ack_dly = 4'h2;
   logic [31:0] prdata, rd_q;
   logic pready, pslverr, irq, trap_irq, irq_ack, err_q;
   logic [7:0] irq_vector;
   logic [3:0] irq_level;
   int n_fail = 0;
   int samples_checked = 0;

   always #10 pclk = ~pclk;

   pic_ctrl #(.N_SRC(16), .N_EXT(3)) i_dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ext_irq_pin(ext_pin), .periph_evt(pevt), .trap_evt(tevt),
      .dma_trap_evt(dma_evt), .loop_ovf_evt(loop_evt),
      .trap_enter(t_enter), .trap_exit(t_exit), .irq_ack, .irq,
      .trap_irq, .irq_vector, .irq_level);
   pic_cpu_model u_cpu (.pclk, .presetn, .irq, .ack_en, .ack_dly,
      .irq_ack);

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_fail++;
         test_done;
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_q, e);
   endtask : rd

   // Bits: trap events, enter, exit, dma, loop overflow
   task automatic fire(input logic [12:0] p, input logic [7:0] t);
      @(posedge pclk);
      pevt <= p;
      {tevt, t_enter, t_exit, dma_evt, loop_evt} <= t;
      @(posedge pclk);
      pevt <= 13'h0;
      {tevt, t_enter, t_exit, dma_evt, loop_evt} <= 8'h0;
   endtask : fire

   task automatic wirq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 16)
      begin
         @(negedge pclk);
         n++;
      end
      chk(32'(irq), 32'(v));
      // A level that never came ends the run
      if (irq !== v)
         test_done;
   endtask : wirq

   // Fixed wait: output latency is one cycle after qualification
   task automatic sirq(input logic v);
      repeat (4) @(negedge pclk);
      chk(32'(irq), 32'(v));
   endtask : sirq

   task automatic pend(input logic [7:0] v, input logic [3:0] l);
      sirq(1'b1);
      chk(32'(irq_vector), 32'(v));
      chk(32'(irq_level), 32'(l));
   endtask : pend

   task automatic t_reset;
      rd(pic_pkg::OFS_STATUS, 32'h0);
      rd(pic_pkg::OFS_PRIO, 32'h4444);
      rd(pic_pkg::OFS_ENAB, 32'h0);
      rd(pic_pkg::OFS_GCTL2, 32'h0);
      rd(8'h1c, 32'h0);
      chk(32'(err_q), 32'h1);
   endtask : t_reset

   task automatic t_basic;
      wr(pic_pkg::OFS_ENAB, 32'h8);
      fire(13'h1, 8'h0);
      sirq(1'b0);
      rd(pic_pkg::OFS_FLAG, 32'h8);
      wr(pic_pkg::OFS_GCTL2, 32'h8000);
      pend(8'h0b, 4'h4);
      rd(pic_pkg::OFS_PEND, 32'h40b);
      wr(pic_pkg::OFS_ENAB, 32'h0);
      sirq(1'b0);
      wr(pic_pkg::OFS_ENAB, 32'h8);
      wirq(1'b1);
      wr(pic_pkg::OFS_FLAG, 32'h8);
      wirq(1'b0);
      rd(pic_pkg::OFS_FLAG, 32'h0);
   endtask : t_basic

   task automatic t_ext;
      wr(pic_pkg::OFS_ENAB, 32'h1);
      @(posedge pclk);
      ext_pin <= 3'h1;
      wirq(1'b1);
      pend(8'h08, 4'h4);
      wr(pic_pkg::OFS_GCTL2, 32'h8001);
      wr(pic_pkg::OFS_FLAG, 32'h1);
      wirq(1'b0);
      @(posedge pclk);
      ext_pin <= 3'h0;
      wirq(1'b1);
      wr(pic_pkg::OFS_GCTL2, 32'h8000);
      wr(pic_pkg::OFS_FLAG, 32'h1);
      wirq(1'b0);
   endtask : t_ext

   task automatic t_prio;
      wr(8'h2c, 32'h4266);
      rd(8'h2c, 32'h4266);
      wr(pic_pkg::OFS_ENAB, 32'h70);
      fire(13'he, 8'h0);
      pend(8'h0c, 4'h6);
      wr(pic_pkg::OFS_FLAG, 32'h10);
      pend(8'h0d, 4'h6);
      wr(pic_pkg::OFS_FLAG, 32'h20);
      pend(8'h0e, 4'h2);
   endtask : t_prio

   task automatic t_level;
      wr(pic_pkg::OFS_STATUS, 32'h40);
      sirq(1'b0);
      wr(pic_pkg::OFS_STATUS, 32'h20);
      wirq(1'b1);
      wr(pic_pkg::OFS_GCTL1, 32'h8000);
      rd(pic_pkg::OFS_GCTL1, 32'h8000);
      wr(pic_pkg::OFS_STATUS, 32'he0);
      rd(pic_pkg::OFS_STATUS, 32'h20);
      sirq(1'b1);
      wr(pic_pkg::OFS_GCTL1, 32'h0);
      wr(8'h2c, 32'h4766);
      wr(pic_pkg::OFS_STATUS, 32'he0);
      sirq(1'b0);
      wr(pic_pkg::OFS_STATUS, 32'hc0);
      wirq(1'b1);
      wr(pic_pkg::OFS_STATUS, 32'h0);
   endtask : t_level

   task automatic t_trap;
      fire(13'h0, 8'h08);
      sirq(1'b0);
      rd(pic_pkg::OFS_CORE, 32'h8);
      wr(pic_pkg::OFS_CORE, 32'h0);
      rd(pic_pkg::OFS_CORE, 32'h8);
      fire(13'h0, 8'h04);
      wirq(1'b1);
      fire(13'h0, 8'h40);
      rd(pic_pkg::OFS_GCTL1, 32'h8);
      wr(pic_pkg::OFS_GCTL1, 32'h8);
      rd(pic_pkg::OFS_GCTL1, 32'h0);
      fire(13'h0, 8'h03);
      rd(pic_pkg::OFS_GCTL3, 32'h30);
      wr(pic_pkg::OFS_GCTL3, 32'h30);
      rd(pic_pkg::OFS_GCTL3, 32'h0);
      wr(pic_pkg::OFS_GCTL4, 32'h1);
      rd(pic_pkg::OFS_GCTL4, 32'h1);
      chk(32'(trap_irq), 32'h1);
      wr(pic_pkg::OFS_GCTL4, 32'h0);
      rd(pic_pkg::OFS_GCTL4, 32'h0);
   endtask : t_trap

   // Prompt and slow acknowledge from the core stand-in
   task automatic t_ack;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge pclk);
         ack_dly <= (i == 0) ? 4'h2 : 4'h9;
         ack_en <= 1'b1;
         wirq(1'b0);
         @(posedge pclk);
         ack_en <= 1'b0;
         rd(pic_pkg::OFS_STATUS, 32'he0);
         wr(pic_pkg::OFS_STATUS, 32'h0);
         wirq(1'b1);
      end
   endtask : t_ack

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_basic;
      t_ext;
      t_prio;
      t_level;
      t_trap;
      t_ack;
      repeat (4) @(posedge pclk);
      test_done;
   end
endmodule : prioritized_interrupt_controller_tb_top
